// ===== rtl/ckoc_defs.vh
// Constants for the clock output configuration controller.
// Assumes a 200 MHz system clock and a 64-byte register space.
`ifndef CKOC_DEFS_VH
`define CKOC_DEFS_VH

`define CKOC_CLK_MHZ        200
`define CKOC_POR_MAX_MS     175
`define CKOC_POR_CYCLES     26'd35000000

`define CKOC_SLAVE_ADDR     7'h6c
`define CKOC_REG_DEPTH      64

`define CKOC_BANK_BASE      16
`define CKOC_BANK_STEP      8
`define CKOC_OFS_DIV        0
`define CKOC_OFS_CTL        2
`define CKOC_OFS_OUT        4
`define CKOC_ADDR_SE_CFG    6'h29
`define CKOC_ADDR_FRAC_CFG  6'h2d
`define CKOC_ADDR_FRAC_HI   6'h2e
`define CKOC_ADDR_FRAC_MID  6'h2f
`define CKOC_ADDR_FRAC_LO   6'h30
`define CKOC_ADDR_DEVCTL    6'h3d
`define CKOC_ADDR_STATUS    8'h3e

`define CKOC_CTL_PD_BIT     7
`define CKOC_CTL_EN_BIT     6
`define CKOC_CTL_SEL_BIT    0
`define CKOC_OUT_PD_BIT     7
`define CKOC_OUT_STY_BIT    2
`define CKOC_SE_EN_BIT      0
`define CKOC_SE_BYP_BIT     1
`define CKOC_FRAC_SEL_BIT   6
`define CKOC_RESYNC_BIT     0

`define CKOC_DIV_DFLT       8'h10
`define CKOC_CTL_DFLT       8'h40
`define CKOC_SE_DFLT        8'h01
`define CKOC_FRAC_DFLT      8'h05

`define CKOC_AMP_350        2'h0
`define CKOC_AMP_750        2'h2
`define CKOC_FINT_MIN       4'h5
`define CKOC_PIN_WHOLE      4'h9
`define CKOC_PIN_SUB        24'h600000

`define CKOC_LVL_LO         2'h0
`define CKOC_LVL_MID        2'h1
`define CKOC_LVL_HI         2'h2

`endif

// ===== rtl/ckoc_i2c_slave.v
// Byte-oriented serial slave: block reads and writes from one register pointer.
// Assumes scl/sda arrive asynchronously; the wired-and level is resolved outside.
`timescale 1ns/10ps
`default_nettype none
`include "ckoc_defs.vh"

module ckoc_i2c_slave (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       enable,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  output wire [7:0] rd_addr,
  input  wire [7:0] rd_data,
  output wire       wr_pulse,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data,
  output wire       stop_pulse
);
  localparam [2:0] P_IDLE = 3'h0;
  localparam [2:0] P_ADDR = 3'h1;
  localparam [2:0] P_REG  = 3'h2;
  localparam [2:0] P_WR   = 3'h3;
  localparam [2:0] P_RD   = 3'h4;

  reg       scl_1, scl_2, scl_p;
  reg       sda_1, sda_2, sda_p;
  reg [2:0] ph_reg;
  reg [3:0] bitc_reg;
  reg [7:0] sh_reg;
  reg [7:0] ptr_reg;
  reg       oe_reg;
  reg       wr_pulse_reg;
  reg [7:0] wr_addr_reg;
  reg [7:0] wr_data_reg;
  reg       stop_pulse_reg;

  wire rise  = scl_2 & ~scl_p;
  wire fall  = ~scl_2 & scl_p;
  wire start = scl_2 & scl_p & sda_p & ~sda_2;
  wire stop  = scl_2 & scl_p & ~sda_p & sda_2;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_1 <= 1'b1;
      scl_2 <= 1'b1;
      scl_p <= 1'b1;
      sda_1 <= 1'b1;
      sda_2 <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_1 <= scl_in; // R19
      scl_2 <= scl_1;
      scl_p <= scl_2;
      sda_1 <= sda_in;
      sda_2 <= sda_1;
      sda_p <= sda_2;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ph_reg         <= P_IDLE;
      bitc_reg       <= 4'h0;
      sh_reg         <= 8'h00;
      ptr_reg        <= 8'h00;
      oe_reg         <= 1'b0;
      wr_pulse_reg   <= 1'b0;
      wr_addr_reg    <= 8'h00;
      wr_data_reg    <= 8'h00;
      stop_pulse_reg <= 1'b0;
    end else begin
      wr_pulse_reg   <= 1'b0;
      stop_pulse_reg <= 1'b0;
      if (!enable) begin // R15
        ph_reg <= P_IDLE;
        oe_reg <= 1'b0;
      end else if (start) begin
        ph_reg   <= P_ADDR;
        bitc_reg <= 4'h0;
        oe_reg   <= 1'b0;
      end else if (stop) begin // R21
        ph_reg         <= P_IDLE;
        oe_reg         <= 1'b0;
        stop_pulse_reg <= 1'b1; // R22
      end else if (ph_reg != P_IDLE) begin
        if (rise) begin
          if (bitc_reg < 4'h8) begin
            sh_reg   <= {sh_reg[6:0], sda_2}; // R20
            bitc_reg <= bitc_reg + 4'h1;
          end else if (bitc_reg == 4'h8) begin
            if (ph_reg == P_RD && sda_2)
              ph_reg <= P_IDLE; // R21
            bitc_reg <= 4'h9;
          end
        end else if (fall) begin
          if (bitc_reg == 4'h8) begin
            case (ph_reg)
              P_ADDR: begin
                if (sh_reg[7:1] == `CKOC_SLAVE_ADDR) begin // R18
                  oe_reg <= 1'b1;
                  ph_reg <= sh_reg[0] ? P_RD : P_REG;
                end else begin
                  ph_reg <= P_IDLE; // R26
                end
              end
              P_REG: begin
                ptr_reg <= sh_reg; // R20
                oe_reg  <= 1'b1;
                ph_reg  <= P_WR;
              end
              P_WR: begin
                wr_pulse_reg <= 1'b1;
                wr_addr_reg  <= ptr_reg;
                wr_data_reg  <= sh_reg;
                ptr_reg      <= ptr_reg + 8'h01; // R20
                oe_reg       <= 1'b1;
              end
              default: oe_reg <= 1'b0;
            endcase
          end else if (bitc_reg == 4'h9) begin
            bitc_reg <= 4'h0;
            if (ph_reg == P_RD) begin
              sh_reg  <= rd_data;
              oe_reg  <= ~rd_data[7]; // R20
              ptr_reg <= ptr_reg + 8'h01;
            end else begin
              oe_reg <= 1'b0;
            end
          end else if (ph_reg == P_RD && bitc_reg != 4'h0) begin
            oe_reg <= ~sh_reg[7];
          end
        end
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe     = oe_reg;
  assign rd_addr    = ptr_reg;
  assign wr_pulse   = wr_pulse_reg;
  assign wr_addr    = wr_addr_reg;
  assign wr_data    = wr_data_reg;
  assign stop_pulse = stop_pulse_reg;

endmodule

`default_nettype wire

// ===== rtl/ckoc_ctrl.v
// Digital control of a four-bank clock generator: pin decode, output states,
// fractional divider ratio, start-up sequencing and the serial register port.
// Assumes pin comparators and pll_lock are asynchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "ckoc_defs.vh"

// Notes on behaviour
// R1 - Fractional ratio is twice (whole plus sub over 2^24) times post factor.
// R2 - Whole part 5..15 from 4 bits, 24-bit fraction, post factor 1/2/4.
// R3 - Powered-down pairs drive both legs high; single-ended output goes high-Z.
// R4 - Each pair has its own swing 350/500/750 mV and LVDS/LVPECL/off choice.
// R5 - Under pin control every pair of a bank shares one configuration.
// R6 - Pin settings drive outputs directly; stored registers never change from pins.
// R7 - Disabled: true leg low, complement high, single-ended low; registers only.
// R8 - All banks enabled by default; bank power and enable set by register bits.
// R9 - Each output can also be powered down alone by a register bit.
// R10 - Banks A/B pin pair decode to fixed LVPECL/LVDS ratios or power-down.
// R11 - Pin-controlled LVPECL uses 750 mV swing, LVDS uses 350 mV.
// R12 - Bank C pin pair decodes to its own ratio table or power-down.
// R13 - Bank D pins pick LVDS ratios, fractional ones, CMOS 75, or bypass.
// R14 - Power-on reset lasts at most 175 ms after power-up.
// R15 - During reset: defaults held, outputs enabled, lock cleared, serial port ignored.
// R16 - After reset, load defaults, then serve serial port and try PLL lock.
// R17 - When the PLL locks, all PLL-fed output dividers are synchronised.
// R18 - Serial slave answers only at seven-bit address 1101100b.
// R19 - Serial port runs at 100 kHz and 400 kHz bus rates.
// R20 - One register-address byte, then ascending addresses, MSB first.
// R21 - A block transfer may end after any complete byte.
// R22 - Written bytes are buffered and all committed together at STOP; the code never stores DEVCTL and only uses it for resync.
// R23 - Writing the resync bit loads new divider values and resynchronises dividers.
// R24 - An open control pin reads as the middle level.
// R25 - Per-bank source bit picks pin (0) or register (1) configuration.
// R26 - Three-level pins are digitised first; other slave addresses get no acknowledge.
module ckoc_ctrl #(
  parameter [25:0] POR_CYCLES = `CKOC_POR_CYCLES
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [1:0]  bank_a_pins_hi,
  input  wire [1:0]  bank_a_pins_lo,
  input  wire [1:0]  bank_b_pins_hi,
  input  wire [1:0]  bank_b_pins_lo,
  input  wire [1:0]  bank_c_pins_hi,
  input  wire [1:0]  bank_c_pins_lo,
  input  wire [1:0]  bank_d_pins_hi,
  input  wire [1:0]  bank_d_pins_lo,
  input  wire        pll_lock,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  output wire        pll_lock_en,
  output wire        cfg_done,
  output wire        div_sync,
  output wire [7:0]  div_ratio_a,
  output wire [7:0]  div_ratio_b,
  output wire [7:0]  div_ratio_c,
  output wire [7:0]  div_ratio_d,
  output wire        frac_sel,
  output wire [3:0]  whole_part_code,
  output wire [23:0] sub_unit_code,
  output wire [2:0]  post_factor,
  output wire [30:0] frac_total_div,
  output wire [10:0] diff_pd,
  output wire [10:0] diff_dis,
  output wire [10:0] diff_style,
  output wire [21:0] diff_amp,
  output wire [10:0] diff_true_lvl,
  output wire [10:0] diff_comp_lvl,
  output wire        se_oe,
  output wire        se_force_low,
  output wire        se_bypass
);
  localparam [1:0] ST_POR = 2'h0;
  localparam [1:0] ST_CFG = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  // Comparator pair to level; neither threshold crossed means middle (open pin)
  function [1:0] lvl(input hi, input lo);
    begin
      if (hi)
        lvl = `CKOC_LVL_HI;
      else if (lo)
        lvl = `CKOC_LVL_LO;
      else
        lvl = `CKOC_LVL_MID; // R24
    end
  endfunction

  // {pd, lvpecl, ratio} for banks A, B and C
  function [9:0] pin_map(input is_c, input [1:0] p1, input [1:0] p0);
    begin
      case ({p1, p0})
        4'h0:    pin_map = is_c ? {2'h1, 8'h08} : {2'h1, 8'h10};
        4'h1:    pin_map = is_c ? {2'h1, 8'h10} : {2'h1, 8'h14};
        4'h2:    pin_map = is_c ? {2'h1, 8'h14} : {2'h1, 8'h19};
        4'h4:    pin_map = {2'h1, 8'h64};
        4'h6:    pin_map = is_c ? {2'h0, 8'h14} : {2'h0, 8'h10};
        4'h8:    pin_map = is_c ? {2'h0, 8'h19} : {2'h0, 8'h14};
        4'h9:    pin_map = is_c ? {2'h0, 8'h32} : {2'h0, 8'h19};
        4'ha:    pin_map = is_c ? {2'h0, 8'h64} : {2'h0, 8'h32};
        default: pin_map = {2'h2, 8'h00};
      endcase
    end
  endfunction

  // Bank D: {pd_diff, se_on, bypass, frac, post_code[1:0], ratio}
  function [13:0] d_map(input [1:0] p1, input [1:0] p0);
    begin
      case ({p1, p0})
        4'h0:    d_map = {4'h0, 2'h0, 8'h19};
        4'h1:    d_map = {4'h0, 2'h0, 8'h32};
        4'h2:    d_map = {4'h1, 2'h0, 8'h00};
        4'h4:    d_map = {4'h1, 2'h1, 8'h00};
        4'h6:    d_map = {4'hc, 2'h0, 8'h4b};
        4'h8:    d_map = {4'h0, 2'h0, 8'h64};
        4'h9:    d_map = {4'h0, 2'h0, 8'h14};
        4'ha:    d_map = {4'h6, 2'h0, 8'h01};
        default: d_map = {4'h8, 2'h0, 8'h00};
      endcase
    end
  endfunction

  function [7:0] dflt(input [5:0] a);
    begin
      if (a == `CKOC_ADDR_SE_CFG)
        dflt = `CKOC_SE_DFLT;
      else if (a == `CKOC_ADDR_FRAC_CFG)
        dflt = `CKOC_FRAC_DFLT;
      else if (a >= 6'h10 && a <= 6'h2f && a[2:0] == `CKOC_OFS_DIV)
        dflt = `CKOC_DIV_DFLT;
      else if (a >= 6'h10 && a <= 6'h2f && a[2:0] == `CKOC_OFS_CTL)
        dflt = `CKOC_CTL_DFLT; // R8
      else
        dflt = 8'h00;
    end
  endfunction

  reg  [7:0]  regs [0:`CKOC_REG_DEPTH-1];
  reg  [7:0]  wbuf [0:`CKOC_REG_DEPTH-1];
  reg  [63:0] pend_reg;
  reg  [16:0] sync1_reg;
  reg  [16:0] sync2_reg;
  reg         lock_p_reg;
  reg  [1:0]  st_reg;
  reg  [25:0] por_cnt_reg;
  reg  [5:0]  cfg_idx_reg;
  reg         div_sync_reg;
  reg  [31:0] div_ratio_reg;
  reg         frac_sel_reg;
  reg  [3:0]  whole_reg;
  reg  [23:0] sub_reg;
  reg  [2:0]  post_reg;
  reg  [30:0] total_reg;
  reg  [10:0] diff_pd_reg;
  reg  [10:0] diff_dis_reg;
  reg  [10:0] diff_style_reg;
  reg  [21:0] diff_amp_reg;
  reg         se_oe_reg;
  reg         se_force_low_reg;
  reg         se_bypass_reg;
  integer     i, j;

  wire        run = (st_reg == ST_RUN);
  wire        lock_s = sync2_reg[16];
  wire [7:0]  rd_addr;
  wire [7:0]  rd_data;
  wire        wr_pulse;
  wire [7:0]  wr_addr;
  wire [7:0]  wr_data;
  wire        stop_pulse;
  wire [3:0]  bk_sel;
  wire [3:0]  bk_pd;
  wire [3:0]  bk_en;
  wire [3:0]  bk_pecl;
  wire [31:0] bk_ratio;
  wire [10:0] pd_next;
  wire [10:0] dis_next;
  wire [10:0] sty_next;
  wire [21:0] amp_next;
  wire [13:0] dm = d_map(lvl(sync2_reg[13], sync2_reg[15]), lvl(sync2_reg[12], sync2_reg[14]));
  wire        resync_req = stop_pulse & pend_reg[`CKOC_ADDR_DEVCTL] &
                           wbuf[`CKOC_ADDR_DEVCTL][`CKOC_RESYNC_BIT];
  wire        sync_next = run & ((lock_s & ~lock_p_reg) | resync_req); // R17 R23

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 17'h00000;
      sync2_reg <= 17'h00000;
    end else begin
      sync1_reg <= {pll_lock, bank_d_pins_lo, bank_d_pins_hi, bank_c_pins_lo, bank_c_pins_hi,
                    bank_b_pins_lo, bank_b_pins_hi, bank_a_pins_lo, bank_a_pins_hi};
      sync2_reg <= sync1_reg; // R26
    end
  end

  // Power-on reset, then one pass of defaults before the port opens
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg      <= ST_POR;
      por_cnt_reg <= 26'h0000000;
      cfg_idx_reg <= 6'h00;
      lock_p_reg  <= 1'b0;
    end else begin
      lock_p_reg  <= lock_s & run;
      cfg_idx_reg <= cfg_idx_reg + 6'h01;
      case (st_reg)
        ST_POR: begin
          por_cnt_reg <= por_cnt_reg + 26'h0000001;
          if (por_cnt_reg == POR_CYCLES - 26'h0000001) begin // R14
            st_reg      <= ST_CFG;
            cfg_idx_reg <= 6'h00;
          end
        end
        ST_CFG: begin
          if (cfg_idx_reg == 6'h3f)
            st_reg <= ST_RUN; // R16
        end
        default: st_reg <= ST_RUN;
      endcase
    end
  end

  // Defaults walk in outside RUN; in RUN a STOP commits every buffered byte except DEVCTL at once
  always @(posedge sys_clk) begin
    if (!run) begin
      regs[cfg_idx_reg] <= dflt(cfg_idx_reg); // R15 R16
    end else if (stop_pulse) begin
      for (j = 0; j < `CKOC_REG_DEPTH; j = j + 1) begin
        if (pend_reg[j] && j != `CKOC_ADDR_DEVCTL)
          regs[j] <= wbuf[j]; // R22
      end
    end
  end

  always @(posedge sys_clk) begin
    if (wr_pulse && wr_addr < 8'h40)
      wbuf[wr_addr[5:0]] <= wr_data; // R22
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      pend_reg <= 64'h0000000000000000;
    else if (!run || stop_pulse)
      pend_reg <= 64'h0000000000000000;
    else if (wr_pulse && wr_addr < 8'h40)
      pend_reg[wr_addr[5:0]] <= 1'b1;
  end

  // Status reads live; lock is hidden outside RUN
  assign rd_data = (rd_addr == `CKOC_ADDR_STATUS) ? {6'h00, run, lock_s & run} :
                   (rd_addr < 8'h40) ? regs[rd_addr[5:0]] : 8'h00;

  genvar b, o;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bank
      localparam integer BI = `CKOC_BANK_BASE + `CKOC_BANK_STEP * b;
      wire [7:0] ctl = regs[BI + `CKOC_OFS_CTL];
      wire [9:0] pm  = pin_map(b == 2, lvl(sync2_reg[4*b+1], sync2_reg[4*b+3]),
                               lvl(sync2_reg[4*b], sync2_reg[4*b+2])); // R10 R12
      assign bk_sel[b]  = ctl[`CKOC_CTL_SEL_BIT]; // R25
      assign bk_en[b]   = ctl[`CKOC_CTL_EN_BIT]; // R8
      assign bk_pecl[b] = (b == 3) ? 1'b0 : pm[8]; // R13
      assign bk_pd[b]   = bk_sel[b] ? ctl[`CKOC_CTL_PD_BIT] : ((b == 3) ? dm[13] : pm[9]);
      assign bk_ratio[8*b+7:8*b] = bk_sel[b] ? regs[BI + `CKOC_OFS_DIV] :
                                   ((b == 3) ? dm[7:0] : pm[7:0]); // R6
    end
    for (o = 0; o < 11; o = o + 1) begin : g_out
      localparam integer B  = (o < 4) ? 0 : (o < 8) ? 1 : (o < 10) ? 2 : 3;
      localparam integer LO = (B == 0) ? 0 : (B == 1) ? 4 : (B == 2) ? 8 : 10;
      wire [7:0] cf = regs[`CKOC_BANK_BASE + `CKOC_BANK_STEP * B + `CKOC_OFS_OUT + o - LO];
      assign pd_next[o]  = bk_pd[B] | (bk_sel[B] & cf[`CKOC_OUT_PD_BIT]); // R9
      assign dis_next[o] = run & bk_sel[B] & ~bk_en[B] & ~pd_next[o]; // R7 R15
      assign sty_next[o] = bk_sel[B] ? cf[`CKOC_OUT_STY_BIT] : bk_pecl[B]; // R4 R5
      assign amp_next[2*o+1:2*o] = bk_sel[B] ? cf[1:0] :
                                   (bk_pecl[B] ? `CKOC_AMP_750 : `CKOC_AMP_350); // R11
    end
  endgenerate

  wire        d_reg = bk_sel[3];
  wire [7:0]  fcfg  = regs[`CKOC_ADDR_FRAC_CFG];
  wire [7:0]  secfg = regs[`CKOC_ADDR_SE_CFG];
  wire [3:0]  w_raw = d_reg ? fcfg[3:0] : `CKOC_PIN_WHOLE;
  wire [3:0]  w_eff = (w_raw < `CKOC_FINT_MIN) ? `CKOC_FINT_MIN : w_raw; // R2
  wire [23:0] s_eff = d_reg ? {regs[`CKOC_ADDR_FRAC_HI], regs[`CKOC_ADDR_FRAC_MID],
                               regs[`CKOC_ADDR_FRAC_LO]} : `CKOC_PIN_SUB;
  wire [1:0]  pcode = d_reg ? fcfg[5:4] : dm[9:8];
  wire [1:0]  psh   = (pcode == 2'h0) ? 2'h0 : (pcode == 2'h1) ? 2'h1 : 2'h2; // R2
  wire [30:0] tot   = {3'h0, w_eff, s_eff} << ({1'b0, psh} + 3'h1); // R1
  wire        se_dis = run & d_reg & ~bk_en[3] & ~bk_pd[3]; // R7
  wire        se_act = d_reg ? (secfg[`CKOC_SE_EN_BIT] & ~bk_pd[3]) : dm[12]; // R3 R13

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_sync_reg     <= 1'b0;
      div_ratio_reg    <= {4{`CKOC_DIV_DFLT}};
      frac_sel_reg     <= 1'b0;
      whole_reg        <= `CKOC_FINT_MIN;
      sub_reg          <= 24'h000000;
      post_reg         <= 3'h1;
      total_reg        <= 31'h0a000000;
      diff_pd_reg      <= 11'h000;
      diff_dis_reg     <= 11'h000;
      diff_style_reg   <= 11'h000;
      diff_amp_reg     <= 22'h000000;
      se_oe_reg        <= 1'b0;
      se_force_low_reg <= 1'b0;
      se_bypass_reg    <= 1'b0;
    end else begin
      div_sync_reg <= sync_next;
      // Register-mode ratios wait for a resync; pin mode follows the pins
      for (i = 0; i < 4; i = i + 1) begin
        if (!run || sync_next || !bk_sel[i])
          div_ratio_reg[8*i +: 8] <= bk_ratio[8*i +: 8]; // R23
      end
      if (!run || sync_next || !d_reg) begin
        frac_sel_reg <= d_reg ? fcfg[`CKOC_FRAC_SEL_BIT] : dm[10];
        whole_reg    <= w_eff;
        sub_reg      <= s_eff;
        post_reg     <= 3'h1 << psh;
        total_reg    <= tot; // R1
      end
      diff_pd_reg      <= pd_next; // R3
      diff_dis_reg     <= dis_next;
      diff_style_reg   <= sty_next;
      diff_amp_reg     <= amp_next;
      se_oe_reg        <= se_act | se_dis;
      se_force_low_reg <= se_dis;
      se_bypass_reg    <= d_reg ? secfg[`CKOC_SE_BYP_BIT] : dm[11];
    end
  end

  ckoc_i2c_slave u_port (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .enable     (run),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data),
    .wr_pulse   (wr_pulse),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .stop_pulse (stop_pulse)
  );

  assign pll_lock_en     = run; // R16
  assign cfg_done        = run;
  assign div_sync        = div_sync_reg;
  assign div_ratio_a     = div_ratio_reg[7:0];
  assign div_ratio_b     = div_ratio_reg[15:8];
  assign div_ratio_c     = div_ratio_reg[23:16];
  assign div_ratio_d     = div_ratio_reg[31:24];
  assign frac_sel        = frac_sel_reg;
  assign whole_part_code = whole_reg;
  assign sub_unit_code   = sub_reg;
  assign post_factor     = post_reg;
  assign frac_total_div  = total_reg;
  assign diff_pd         = diff_pd_reg;
  assign diff_dis        = diff_dis_reg;
  assign diff_style      = diff_style_reg;
  assign diff_amp        = diff_amp_reg;
  assign diff_true_lvl   = diff_pd_reg; // R3 R7
  assign diff_comp_lvl   = diff_pd_reg | diff_dis_reg;
  assign se_oe           = se_oe_reg;
  assign se_force_low    = se_force_low_reg;
  assign se_bypass       = se_bypass_reg;

endmodule

`default_nettype wire

// ===== dv/ckoc_ctrl_asserts.sv
// Checker for ckoc_ctrl output relations.
// Assumes it is bound onto the top module ports.
`timescale 1ns/10ps
`default_nettype none
module ckoc_ctrl_asserts (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [1:0]  bank_a_pins_hi,
  input wire logic [1:0]  bank_a_pins_lo,
  input wire logic        pll_lock,
  input wire logic        sda_oe,
  input wire logic        cfg_done,
  input wire logic        div_sync,
  input wire logic [3:0]  whole_part_code,
  input wire logic [23:0] sub_unit_code,
  input wire logic [2:0]  post_factor,
  input wire logic [30:0] frac_total_div,
  input wire logic [10:0] diff_pd,
  input wire logic [10:0] diff_dis,
  input wire logic [10:0] diff_true_lvl,
  input wire logic [10:0] diff_comp_lvl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence mid_s;
    !cfg_done && bank_a_pins_hi == 2'h0 && bank_a_pins_lo == 2'h0;
  endsequence
  sequence calm_s;
    $stable(whole_part_code) && $stable(sub_unit_code) && $stable(post_factor);
  endsequence
  lock_sync_a: assert property ($rose(pll_lock) && cfg_done |-> ##[1:6] div_sync)
    else $error("no sync after lock");
  sync_pulse_a: assert property (div_sync |=> !div_sync)
    else $error("sync too long");
  quiet_por_a: assert property (!cfg_done |-> !sda_oe && diff_dis == 11'h0)
    else $error("active in reset");
  pd_legs_a: assert property (|diff_pd |-> (diff_true_lvl & diff_comp_lvl & diff_pd) == diff_pd)
    else $error("pd legs wrong");
  dis_legs_a: assert property (|diff_dis |-> (diff_dis & ~diff_pd & (diff_true_lvl | ~diff_comp_lvl)) == 11'h0)
    else $error("dis legs wrong");
  pin_mid_a: assert property (mid_s [*5] |-> diff_pd[3:0] == 4'hf)
    else $error("open pins not off");
  frac_calc_a: assert property (calm_s ##1 calm_s |->
    frac_total_div == {3'h0, whole_part_code, sub_unit_code} * post_factor * 31'h2) else $error("bad ratio");
  codes_ok_a: assert property (whole_part_code >= 4'h5 && post_factor inside {3'h1, 3'h2, 3'h4})
    else $error("bad codes");
endmodule
bind ckoc_ctrl ckoc_ctrl_asserts chk (.sys_clk(sys_clk), .rstn(rstn), .bank_a_pins_hi(bank_a_pins_hi),
  .bank_a_pins_lo(bank_a_pins_lo), .pll_lock(pll_lock), .sda_oe(sda_oe), .cfg_done(cfg_done),
  .div_sync(div_sync), .whole_part_code(whole_part_code), .sub_unit_code(sub_unit_code),
  .post_factor(post_factor), .frac_total_div(frac_total_div), .diff_pd(diff_pd), .diff_dis(diff_dis),
  .diff_true_lvl(diff_true_lvl), .diff_comp_lvl(diff_comp_lvl));
`default_nettype wire

// ===== dv/ckoc_i2c_master.sv
// Serial bus master model: 48 ns link clock, pulls data low only.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module ckoc_i2c_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Clock stands still high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    #12 sda_low = !b;
    #12 scl = 1'b1;
    #24 r = sda;
    scl = 1'b0;
  endtask
  // Late release leaves room for the slave to drop its acknowledge
  task automatic start;
    #24 sda_low = 1'b0;
    #12 scl = 1'b1;
    #12 sda_low = 1'b1;
    #24 scl = 1'b0;
  endtask
  task automatic stop;
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #24 sda_low = 1'b0;
    #24;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule
`default_nettype wire

// ===== dv/ckoc_ctrl_bench.sv
// Self-checking bench for ckoc_ctrl: start-up, pin decode, serial access.
// Assumes the master model drives the link; data line pulled up here.
`timescale 1ns/10ps
`default_nettype none
module ckoc_ctrl_bench;
  logic             sys_clk, rstn, pll_lock, a;
  logic [1:0]       ph [4];
  logic [1:0]       pl [4];
  logic [15:0]      q;
  int               failures, n_tests, i;
  int               ra [9] = '{16, 20, 25, 100, 0, 16, 20, 25, 50};
  wire logic        scl, m_low, sda_oe, sda_out, cfg_done, div_sync, frac_sel, se_oe, se_bypass;
  wire logic [7:0]  div_ratio_a, div_ratio_c;
  wire logic [3:0]  whole_part_code;
  wire logic [2:0]  post_factor;
  wire logic [30:0] frac_total_div;
  wire logic [10:0] diff_pd, diff_dis, diff_style, diff_true_lvl, diff_comp_lvl;
  wire logic [21:0] diff_amp;
  wire logic        sda = !(m_low | (sda_oe & !sda_out));
  ckoc_ctrl #(.POR_CYCLES(26'h32)) uut (.sys_clk(sys_clk), .rstn(rstn), .bank_a_pins_hi(ph[0]),
    .bank_a_pins_lo(pl[0]), .bank_b_pins_hi(ph[1]), .bank_b_pins_lo(pl[1]), .bank_c_pins_hi(ph[2]),
    .bank_c_pins_lo(pl[2]), .bank_d_pins_hi(ph[3]), .bank_d_pins_lo(pl[3]), .pll_lock(pll_lock),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .pll_lock_en(), .cfg_done(cfg_done),
    .div_sync(div_sync), .div_ratio_a(div_ratio_a), .div_ratio_b(), .div_ratio_c(div_ratio_c),
    .div_ratio_d(), .frac_sel(frac_sel), .whole_part_code(whole_part_code), .sub_unit_code(),
    .post_factor(post_factor), .frac_total_div(frac_total_div), .diff_pd(diff_pd), .diff_dis(diff_dis),
    .diff_style(diff_style), .diff_amp(diff_amp), .diff_true_lvl(diff_true_lvl),
    .diff_comp_lvl(diff_comp_lvl), .se_oe(se_oe), .se_force_low(), .se_bypass(se_bypass));
  ckoc_i2c_master mst (.scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wait_hi(input logic s, input int lim);
    int k;
    k = 0;
    while (((s ? div_sync : cfg_done) !== 1'b1) && k < lim) begin
      @(posedge sys_clk);
      #1 k++;
    end
    chk("wait", k < lim, 1'h1);
    if (k == lim) end_sim;
  endtask
  task setpin(input int b, input int l1, input int l0);
    @(negedge sys_clk);
    ph[b] = {l1 == 2, l0 == 2};
    pl[b] = {l1 == 0, l0 == 0};
    repeat (6) @(negedge sys_clk);
  endtask
  task i2c_wr(input logic [7:0] ptr, input logic [23:0] d, input int n);
    mst.start;
    mst.wbyte(8'hd8, a);
    chk("ack", a, 1'h1);
    mst.wbyte(ptr, a);
    for (int k = 0; k < n; k++) mst.wbyte(d[23 - 8 * k -: 8], a);
  endtask
  initial begin
    rstn = 1'b0;
    pll_lock = 1'b0;
    failures = 0;
    n_tests = 0;
    for (i = 0; i < 4; i++) begin
      ph[i] = 2'h0;
      pl[i] = 2'h0;
    end
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    // Address sent while power-on reset and the default pass still run
    mst.start;
    mst.wbyte(8'hd8, a);
    chk("por_ack", a, 1'h0);
    chk("por_done", cfg_done, 1'h0);
    mst.stop;
    wait_hi(1'h0, 100);
    $display("test por done");
    for (i = 0; i < 9; i++) begin
      setpin(0, i / 3, i % 3);
      chk("pd_a", diff_pd[3:0], i == 4 ? 4'hf : 4'h0);
      if (i != 4) begin
        chk("ratio_a", div_ratio_a, ra[i]);
        chk("style_a", diff_style[3:0], i < 4 ? 4'hf : 4'h0);
        chk("amp_a", diff_amp[7:0], i < 4 ? 8'haa : 8'h0);
      end
    end
    setpin(2, 0, 0);
    chk("ratio_c", div_ratio_c, 8'h8);
    setpin(3, 0, 2);
    chk("frac", {frac_sel, whole_part_code, post_factor}, 8'hc9);
    chk("frac_total", frac_total_div, 31'h12c00000);
    setpin(3, 2, 2);
    chk("bypass", {se_oe, se_bypass}, 2'h3);
    $display("test pins done");
    mst.start;
    mst.wbyte(8'hda, a);
    chk("bad_addr", a, 1'h0);
    mst.stop;
    i2c_wr(8'h12, 24'h410080, 3);
    chk("pd_hold", diff_pd[0], 1'h0);
    mst.stop;
    repeat (6) @(negedge sys_clk);
    chk("pd_q0", diff_pd[1:0], 2'h1);
    chk("pd_legs", {diff_true_lvl[0], diff_comp_lvl[0]}, 2'h3);
    i2c_wr(8'h12, 24'h0, 0);
    mst.start;
    mst.wbyte(8'hd9, a);
    mst.rbyte(1'b0, q[15:8]);
    mst.rbyte(1'b1, q[7:0]);
    mst.stop;
    chk("readback", q, 16'h4100);
    i2c_wr(8'h12, 24'h010000, 1);
    mst.stop;
    repeat (6) @(negedge sys_clk);
    chk("dis_legs", {diff_dis[1], diff_true_lvl[1], diff_comp_lvl[1]}, 3'h5);
    i2c_wr(8'h3d, 24'h010000, 1);
    fork
      mst.stop;
      wait_hi(1'h1, 40);
    join
    @(negedge sys_clk);
    pll_lock = 1'b1;
    wait_hi(1'h1, 10);
    $display("test regs done");
    end_sim;
  end
endmodule
`default_nettype wire
